// ==== hdl/ccg_pkg.sv ====
// shared constants for the clock network enable gate and its user-side controller
package ccg_pkg;
  localparam int NUM_NETS = 4;
  localparam int NUM_PLLS = 2;
  localparam int CNT_W    = 16;

  // network source codes, two bits per network
  localparam logic [1:0] NSRC_PIN     = 2'h0;
  localparam logic [1:0] NSRC_PLL     = 2'h1;
  localparam logic [1:0] NSRC_OFF     = 2'h2;
  localparam logic [1:0] NSRC_PLL_ALT = 2'h3;
  localparam logic [2*NUM_NETS-1:0] NET_SRC_DEFAULT = 8'h65;

  // pll reference codes, two bits per pll
  localparam logic [1:0] PREF_PIN     = 2'h0;
  localparam logic [1:0] PREF_NET     = 2'h1;
  localparam logic [1:0] PREF_CASCADE = 2'h2;
  localparam logic [1:0] PREF_OFF     = 2'h3;
  localparam logic [2*NUM_PLLS-1:0] PLL_REF_DEFAULT = 4'h8;

  // timing of the behavioural pll, in clk_in cycles; LOCK_EDGES counts reference edges
  localparam int PLL_HALF_CYC  = 4;
  localparam int LOCK_EDGES    = 8;
  localparam int LOSS_CYC      = 64;

  localparam logic GATE_RST = 1'b0;

  // apb register map
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] CTRL_OFF      = 12'h000;
  localparam logic [11:0] STATUS_OFF    = 12'h004;
  localparam int          NET_LSB       = 0;
  localparam int          PIN_LSB       = 8;
  localparam int          LOCK_LSB      = 16;
  localparam int          HOLD_BIT      = 31;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
endpackage

// ==== hdl/ccg_link_if.sv ====
// link between the gated clock networks and the user logic that enables them
interface ccg_link_if #(
  parameter int N_NET = ccg_pkg::NUM_NETS,
  parameter int N_PLL = ccg_pkg::NUM_PLLS
);
  logic [N_NET-1:0] net_enable;
  logic [N_PLL-1:0] pin_enable;
  logic [N_NET-1:0] global_clock_net;
  logic [N_PLL-1:0] pll_external_clock_pin;
  logic [N_PLL-1:0] pll_locked;

  modport dev (
    input  net_enable,
    input  pin_enable,
    output global_clock_net,
    output pll_external_clock_pin,
    output pll_locked
  );
  modport usr (
    output net_enable,
    output pin_enable,
    input  global_clock_net,
    input  pll_external_clock_pin,
    input  pll_locked
  );
endinterface

// ==== hdl/ccg_device.sv ====
// clock control: pll models, static reference and source muxes, enable gates
// Functional notes
// - gate acts on network, not pll counter
// - same gate on external pll pin paths
// - sync register on enable for async enables
// - sync register bypassable at build time
// - enable sampled on source clock falling edge
// - pll pin paths never offer the bypass
// - bypass choice is static configuration only
// - gating never disturbs pll loop counters
// - user may hold enable low during resync
// - pll reference from pin, network, neighbour
// - reference select fixed by configuration only
// - network reference carries pll or pin clock
// - no logic-made or gpio clock as reference
// - adjacent plls have direct cascade link
// - dynamic enable; unused networks powered down
module ccg_device #(
  parameter int               N_NET           = ccg_pkg::NUM_NETS,
  parameter int               N_PLL           = ccg_pkg::NUM_PLLS,
  parameter logic [2*N_NET-1:0] NET_SRC       = ccg_pkg::NET_SRC_DEFAULT,
  parameter logic [N_NET-1:0] NET_SYNC_BYPASS = '0,
  parameter logic [2*N_PLL-1:0] PLL_REF_SEL   = ccg_pkg::PLL_REF_DEFAULT,
  parameter int               PLL_HALF        = ccg_pkg::PLL_HALF_CYC,
  parameter int               LOCK_EDGES      = ccg_pkg::LOCK_EDGES,
  parameter int               LOSS_CYC        = ccg_pkg::LOSS_CYC
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [N_PLL-1:0] ref_pin_in,
  ccg_link_if.dev               link
);
  localparam int CW     = ccg_pkg::CNT_W;
  localparam int N_PATH = N_NET + N_PLL;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic rose(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

  // dedicated clock pins arrive asynchronously
  logic [N_PLL-1:0] pin_s1_r;
  logic [N_PLL-1:0] pin_s2_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= ref_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [N_PLL-1:0]  pll_clk_r;
  logic [N_PLL-1:0]  locked_r;
  logic [N_PLL-1:0]  pll_ref;
  logic [N_PLL-1:0]  ref_prev_r;
  logic [N_NET-1:0]  net_src;
  logic [N_PATH-1:0] gated_r;

  // static source mux per network; code off leaves a network powered down
  for (genvar k = 0; k < N_NET; k++) begin : g_net_src
    wire logic [1:0] code = NET_SRC[2*k +: 2];
    assign net_src[k] = (code == ccg_pkg::NSRC_PIN)     ? pin_s2_r[k % N_PLL] :
                        (code == ccg_pkg::NSRC_PLL)     ? pll_clk_r[k % N_PLL] :
                        (code == ccg_pkg::NSRC_PLL_ALT) ? pll_clk_r[(k + 1) % N_PLL] :
                        1'b0;
  end

  for (genvar p = 0; p < N_PLL; p++) begin : g_pll
    wire logic [1:0] rsel = PLL_REF_SEL[2*p +: 2];
    // the neighbour's clock comes on its own wire, never through a network
    wire logic       cascade_in = pll_clk_r[(p + N_PLL - 1) % N_PLL];
    // select is a parameter: no run-time path can change it
    assign pll_ref[p] = (rsel == ccg_pkg::PREF_PIN)     ? pin_s2_r[p] :
                        (rsel == ccg_pkg::PREF_NET)     ? gated_r[p % N_NET] :
                        (rsel == ccg_pkg::PREF_CASCADE) ? cascade_in :
                        1'b0;

    logic [CW-1:0] loop_cnt_r;
    logic [CW-1:0] edge_cnt_r;
    logic [CW-1:0] idle_cnt_r;
    wire logic     ref_edge  = rose(ref_prev_r[p], pll_ref[p]);
    wire logic     loop_wrap = (loop_cnt_r == CW'(PLL_HALF - 1));
    wire logic     ref_lost  = (idle_cnt_r == CW'(LOSS_CYC - 1));
    wire logic     lock_hit  = (edge_cnt_r == CW'(LOCK_EDGES - 1));

    // loop counter free-runs on clk_in and ignores the reference; no enable reaches it
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        loop_cnt_r <= '0;
        pll_clk_r[p] <= ccg_pkg::GATE_RST;
      end else if (loop_wrap) begin
        loop_cnt_r <= '0;
        pll_clk_r[p] <= ~pll_clk_r[p];
      end else begin
        loop_cnt_r <= loop_cnt_r + CW'(1);
      end
    end

    // count reference edges towards lock and idle cycles towards loss
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        ref_prev_r[p] <= 1'b0;
        edge_cnt_r    <= '0;
        idle_cnt_r    <= '0;
      end else begin
        ref_prev_r[p] <= pll_ref[p];
        if (ref_edge) begin
          idle_cnt_r <= '0;
          if (!lock_hit) begin
            edge_cnt_r <= edge_cnt_r + CW'(1);
          end
        end else if (ref_lost) begin
          edge_cnt_r <= '0;
        end else begin
          idle_cnt_r <= idle_cnt_r + CW'(1);
        end
      end
    end

    // a reference edge wins over a loss falling in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        locked_r[p] <= 1'b0;
      end else if (ref_edge & lock_hit) begin
        locked_r[p] <= 1'b1;
      end else if (ref_lost & ~ref_edge) begin
        locked_r[p] <= 1'b0;
      end
    end
  end

  // one gate per path: networks first, then external pll pins
  for (genvar g = 0; g < N_PATH; g++) begin : g_gate
    logic src;
    logic en;
    logic bypass;
    logic src_prev_r;
    logic enable_sync_stage_one;
    logic enable_sync_stage_two;
    logic eff_en_r;

    if (g < N_NET) begin : g_net_path
      assign src    = net_src[g];
      assign en     = link.net_enable[g];
      assign bypass = NET_SYNC_BYPASS[g];
    end else begin : g_pin_path
      assign src    = pll_clk_r[g - N_NET];
      assign en     = link.pin_enable[g - N_NET];
      // pin paths always keep both stages
      assign bypass = 1'b0;
    end

    // a fall shows in the first clk cycle that the source level is low
    wire logic src_fall   = fell(src_prev_r, src);
    wire logic eff_en_nxt = bypass ? en : enable_sync_stage_two;

    // enable moves only at a falling edge of the source, while it is low
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        src_prev_r            <= 1'b0;
        enable_sync_stage_one <= 1'b0;
      end else begin
        src_prev_r <= src;
        if (src_fall) begin
          enable_sync_stage_one <= en;
        end
      end
    end

    // only the first stage feeds the second, as a two-flop chain must
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        enable_sync_stage_two <= 1'b0;
      end else if (src_fall) begin
        enable_sync_stage_two <= enable_sync_stage_one;
      end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        eff_en_r <= 1'b0;
      end else if (src_fall) begin
        eff_en_r <= eff_en_nxt;
      end
    end

    // eff_en_r can only change while src is low, so no runt pulse escapes
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        gated_r[g] <= ccg_pkg::GATE_RST;
      end else begin
        gated_r[g] <= src & eff_en_r;
      end
    end
  end

  assign link.global_clock_net       = gated_r[N_NET-1:0];
  assign link.pll_external_clock_pin = gated_r[N_PATH-1:N_NET];
  assign link.pll_locked             = locked_r;
endmodule

// ==== hdl/ccg_user_ctrl.sv ====
// user-side logic: apb registers that drive the clock enables
module ccg_user_ctrl #(
  parameter int N_NET = ccg_pkg::NUM_NETS,
  parameter int N_PLL = ccg_pkg::NUM_PLLS
) (
  input  wire logic                      clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [ccg_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  ccg_link_if.usr                        link
);
  logic [31:0]      ctrl_r;
  logic [31:0]      prdata_r;
  logic [N_NET-1:0] net_en_r;
  logic [N_PLL-1:0] pin_en_r;

  wire logic hit_ctrl   = (paddr_in == ccg_pkg::CTRL_OFF);
  wire logic hit_status = (paddr_in == ccg_pkg::STATUS_OFF);
  wire logic setup      = psel_in & ~penable_in;
  wire logic access     = psel_in & penable_in;
  wire logic hold       = ctrl_r[ccg_pkg::HOLD_BIT];

  // with the hold bit set, an unlocked pll holds every net and its own pin clock off to hide overshoot
  wire logic [N_NET-1:0] net_en_nxt = ctrl_r[ccg_pkg::NET_LSB +: N_NET] &
                                      {N_NET{~hold | (&link.pll_locked)}};
  wire logic [N_PLL-1:0] pin_en_nxt = ctrl_r[ccg_pkg::PIN_LSB +: N_PLL] &
                                      (~{N_PLL{hold}} | link.pll_locked);

  logic [31:0] status;
  always_comb begin
    status = '0;
    status[ccg_pkg::NET_LSB +: N_NET]  = net_en_r;
    status[ccg_pkg::PIN_LSB +: N_PLL]  = pin_en_r;
    status[ccg_pkg::LOCK_LSB +: N_PLL] = link.pll_locked;
  end

  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_r : (hit_status ? status : '0);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= ccg_pkg::CTRL_RST;
    end else if (access & pwrite_in & hit_ctrl) begin
      ctrl_r <= pwdata_in;
    end
  end

  // read data captured in the setup cycle so it stands through the access phase
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_r <= '0;
    end else if (setup & ~pwrite_in) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      net_en_r <= '0;
      pin_en_r <= '0;
    end else begin
      net_en_r <= net_en_nxt;
      pin_en_r <= pin_en_nxt;
    end
  end

  assign prdata_out      = prdata_r;
  assign pready_out      = 1'b1;
  assign pslverr_out     = access & ~(hit_ctrl | hit_status);
  assign link.net_enable = net_en_r;
  assign link.pin_enable = pin_en_r;
endmodule

// ==== testbench/ccg_link_checker.sv ====
// assertions on the link between the enable gates and the user logic
module ccg_link_checker (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic [3:0] net_enable,
  input wire logic [1:0] pin_enable,
  input wire logic [3:0] global_clock_net,
  input wire logic [1:0] pll_external_clock_pin,
  input wire logic [1:0] pll_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] en_v;
  logic [5:0] ck_v;
  logic [5:0] off_r [6];
  assign en_v = {pin_enable, net_enable};
  assign ck_v = {pll_external_clock_pin, global_clock_net};
  // saturating count of cycles each enable has stayed low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    for (int k = 0; k < 6; k++) begin
      if (!reset_n_in) off_r[k] <= 6'h00;
      else if (en_v[k]) off_r[k] <= 6'h00;
      else if (off_r[k] != 6'h3f) off_r[k] <= off_r[k] + 6'h01;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_low8(logic s);
    !s [*8];
  endsequence
  a_net_off_low: assert property (off_r[0] >= 6'h20 |-> !ck_v[0])
    else $error("net 0 clock runs while disabled");
  a_pinnet_off_low: assert property (off_r[3] >= 6'h20 |-> !ck_v[3])
    else $error("pin fed net clock runs while disabled");
  a_pin_off_low: assert property (off_r[4] >= 6'h20 |-> !ck_v[4])
    else $error("pll pin clock runs while disabled");
  a_net_on_soon: assert property ($rose(en_v[0]) |-> ##[1:40] (ck_v[0] || !en_v[0]))
    else $error("net 0 clock not enabled in time");
  a_pin_on_soon: assert property ($rose(en_v[5]) |-> ##[1:40] (ck_v[5] || !en_v[5]))
    else $error("pll pin 1 clock not enabled in time");
  a_net_sync_delay: assert property ($rose(en_v[1]) && off_r[1] >= 6'h20 |->
    s_low8(ck_v[1]) ##1 s_low8(ck_v[1]))
    else $error("net 1 enable bypassed the sync stages");
  a_pin_sync_path: assert property ($rose(en_v[4]) && off_r[4] >= 6'h20 |->
    s_low8(ck_v[4]) ##1 s_low8(ck_v[4]))
    else $error("pll pin 0 enable bypassed the sync stages");
  a_whole_pulse: assert property ($rose(ck_v[0]) |-> ck_v[0] [*4])
    else $error("runt pulse on net 0");
  a_unused_net_low: assert property (!ck_v[2])
    else $error("unused net 2 clock is running");
  a_bypass_fast: assert property ($rose(en_v[0]) |-> ##[1:14] (ck_v[0] || !en_v[0]))
    else $error("bypassed net 0 enable too slow");
endmodule

// ==== testbench/clock_network_enable_gate_bench.sv ====
// self-checking bench: user controller driving the enable gates over the link
module clock_network_enable_gate_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, reset_n_in, psel, penable, pwrite, pslverr, pready, er, ref_run;
  logic [1:0]  ref_pin = 2'h0;
  logic [2:0]  ref_cnt = 3'h0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, samples_checked;
  // control word written, status expected once plls are locked
  logic [31:0] rows [4][2] = '{'{32'h0000_030F, 32'h0003_030F},
    '{32'h0000_0105, 32'h0003_0105}, '{32'h8000_020A, 32'h0003_020A},
    '{32'h0000_0000, 32'h0003_0000}};
  ccg_link_if link ();
  // net0 pll0 bypassed, net1 pll1, net2 unused, net3 pin1; plls from pin0 and cascade
  ccg_device #(.NET_SRC(8'h25), .NET_SYNC_BYPASS(4'h1), .LOCK_EDGES(2), .LOSS_CYC(32),
    .PLL_REF_SEL(ccg_pkg::PLL_REF_DEFAULT)) ccg_device_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .ref_pin_in(ref_pin), .link(link));
  ccg_user_ctrl ccg_user_ctrl_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link));
  ccg_link_checker ccg_link_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .net_enable(link.net_enable), .pin_enable(link.pin_enable),
    .global_clock_net(link.global_clock_net),
    .pll_external_clock_pin(link.pll_external_clock_pin), .pll_locked(link.pll_locked));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // reference pins: four cycles high, four low; pin 0 can be stopped
  always @(posedge clk_in) begin
    ref_cnt <= ref_cnt + 3'h1;
    ref_pin <= {ref_cnt[2], ref_cnt[2] & ref_run};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ref_run = 1'b1;
    reset_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    apb(1'b0, ccg_pkg::CTRL_OFF, 32'h0);
    check(rd, ccg_pkg::CTRL_RST);
    apb(1'b0, ccg_pkg::STATUS_OFF, 32'h0);
    check(rd, 32'h0000_0000);
    repeat (60) @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ccg_pkg::CTRL_OFF, rows[i][0]);
      repeat (64) @(posedge clk_in);
      apb(1'b0, ccg_pkg::STATUS_OFF, 32'h0);
      check(rd, rows[i][1]);
    end
    // status is read only; unmapped offset errors and reads zero
    apb(1'b1, ccg_pkg::STATUS_OFF, 32'hFFFF_FFFF);
    check({31'h0, er}, 32'h0000_0000);
    apb(1'b0, ccg_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0);
    check({rd[31:1], er}, 32'h0000_0001);
    // hold keeps nets and pin 0 off while pll 0 has lost its reference
    apb(1'b1, ccg_pkg::CTRL_OFF, 32'h8000_030F);
    ref_run <= 1'b0;
    repeat (100) @(posedge clk_in);
    apb(1'b0, ccg_pkg::STATUS_OFF, 32'h0);
    check(rd, 32'h0002_0200);
    ref_run <= 1'b1;
    repeat (80) @(posedge clk_in);
    apb(1'b0, ccg_pkg::STATUS_OFF, 32'h0);
    check(rd, 32'h0003_030F);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    apb(1'b0, ccg_pkg::CTRL_OFF, 32'h0);
    check(rd, ccg_pkg::CTRL_RST);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    close_out();
  end
endmodule
